// [hdl/sapf_pkg.sv]
// shared constants for the converter control block
package sapf_pkg;
   // register indices; byte address is four times the index
   localparam int unsigned ADDR_W     = 18;
   localparam logic [15:0] IDX_RESULT = 16'hff08;
   localparam logic [15:0] IDX_MODE   = 16'hff28;
   localparam logic [15:0] IDX_CHAN   = 16'hff29;
   localparam logic [15:0] IDX_PFMODE = 16'hff2a;
   localparam logic [15:0] IDX_PFTHR  = 16'hff2b;
   localparam logic [15:0] IDX_STATUS = 16'hff2c;
   // mode and channel register fields
   localparam int unsigned MODE_RUN_BIT  = 7;
   localparam int unsigned MODE_TSEL_LSB = 3;
   localparam int unsigned MODE_REF_BIT  = 0;
   localparam logic [7:0]  MODE_MASK     = 8'hb9;
   localparam logic [7:0]  CHAN_MASK     = 8'h07;
   // power-fail mode fields
   localparam int unsigned PF_EN_BIT  = 7;
   localparam int unsigned PF_POL_BIT = 6;
   localparam logic [7:0]  PF_MASK    = 8'hc0;
   // status fields
   localparam int unsigned ST_ACTIVE_BIT  = 0;
   localparam int unsigned ST_INVALID_BIT = 1;
   localparam int unsigned ST_REF_BIT     = 2;
   // reset values
   localparam logic [7:0]  RST_REG8   = 8'h00;
   localparam logic [9:0]  RST_RESULT = 10'h000;
   // converter geometry and timing
   localparam int unsigned RES_W        = 10;
   localparam int unsigned NUM_CH       = 8;
   localparam int unsigned SLOTS        = 24;
   localparam logic [4:0]  SAMPLE_SLOTS = 5'h0e;
   localparam logic [9:0]  MSB_TRIAL    = 10'h200;
   // bus responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // main-clock cycles of one slot; a conversion is SLOTS slots
   function automatic logic [3:0] slot_cycles(input logic [2:0] code);
      unique case (code)
         3'h0:    slot_cycles = 4'hc;
         3'h1:    slot_cycles = 4'ha;
         3'h2:    slot_cycles = 4'h8;
         3'h4:    slot_cycles = 4'h6;
         3'h5:    slot_cycles = 4'h5;
         3'h6:    slot_cycles = 4'h4;
         default: slot_cycles = 4'hc; // prohibited: longest time
      endcase
   endfunction : slot_cycles
endpackage : sapf_pkg

// [hdl/sapf_conv_if.sv]
// link between register side and approximation sequencer
interface sapf_conv_if;
   logic       run;
   logic [2:0] time_code;
   logic       cmp_high;
   logic       sampling;
   logic [9:0] approx;
   logic       active;
   logic       done;
   logic [9:0] result;
   modport ctl (output run, time_code, cmp_high,
                input  sampling, approx, active, done, result);
   modport seq (input  run, time_code, cmp_high,
                output sampling, approx, active, done, result);
endinterface : sapf_conv_if

// [hdl/sapf_sar.sv]
// sample, hold and successive approximation sequencer
module sapf_sar (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control link
   sapf_conv_if.seq  conv
);
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sapf_state_e;

   sapf_state_e state_q;
   logic [8:0]  cnt_q;
   logic [3:0]  slot_q;
   logic [3:0]  bit_q;
   logic [9:0]  approx_q;
   logic [9:0]  result_q;
   logic        sampling_q;
   logic        done_q;
   logic [9:0]  decided;

   // trial bit kept only while the comparator says input is at or above tap
   always_comb begin
      decided = approx_q;
      if (!conv.cmp_high) begin
         decided[bit_q] = 1'b0;
      end
   end

   // time code latched per conversion: a rewrite cannot stretch one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 9'h000;
         slot_q     <= 4'h0;
         bit_q      <= 4'h0;
         approx_q   <= sapf_pkg::RST_RESULT;
         result_q   <= sapf_pkg::RST_RESULT;
         sampling_q <= 1'b0;
         done_q     <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (conv.run) begin // [R10] [R20]
                  state_q    <= ST_SAMPLE;
                  slot_q     <= sapf_pkg::slot_cycles(conv.time_code); // [R08]
                  cnt_q      <= 9'(sapf_pkg::slot_cycles(conv.time_code))
                                * 9'(sapf_pkg::SAMPLE_SLOTS) - 9'h002;
                  sampling_q <= 1'b1; // [R02]
                  approx_q   <= sapf_pkg::RST_RESULT;
               end
            end
            ST_SAMPLE: begin
               if (!conv.run) begin
                  state_q    <= ST_IDLE;
                  sampling_q <= 1'b0;
               end else if (cnt_q == 9'h000) begin
                  state_q    <= ST_CONVERT;
                  sampling_q <= 1'b0; // hold until the last bit [R02]
                  approx_q   <= sapf_pkg::MSB_TRIAL; // [R03]
                  bit_q      <= 4'h9;
                  cnt_q      <= 9'(slot_q - 4'h1);
               end else begin
                  cnt_q <= cnt_q - 9'h001;
               end
            end
            ST_CONVERT: begin
               if (!conv.run) begin
                  state_q <= ST_IDLE; // stopped: result discarded
               end else if (cnt_q != 9'h000) begin
                  cnt_q <= cnt_q - 9'h001;
               end else if (bit_q == 4'h0) begin
                  result_q <= decided; // [R03] [R20]
                  approx_q <= decided;
                  done_q   <= 1'b1;
                  state_q  <= ST_IDLE; // restarts sampling next edge
               end else begin
                  approx_q             <= decided;
                  approx_q[bit_q - 1]  <= 1'b1; // [R03]
                  bit_q                <= bit_q - 4'h1;
                  cnt_q                <= 9'(slot_q - 4'h1);
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // link outputs
   assign conv.sampling = sampling_q;
   assign conv.approx   = approx_q;
   assign conv.active   = (state_q != ST_IDLE);
   assign conv.done     = done_q;
   assign conv.result   = result_q;
endmodule : sapf_sar

// [hdl/sapf_top.sv]
// converter control top: register file, bus slave, power-fail compare
//
// Overview of operation
// R01 - only selected input goes to the converter; others stay digital inputs
// R02 - sample selected input at start, hold it for the whole conversion
// R03 - approximation resolves from msb; at lsb it is copied to result
// R04 - 16-bit result holds value in upper 10 bits, lower 6 zero
// R05 - with power-fail on, interrupt only when chosen comparison holds
// R06 - mode register resets to zero; written by byte or bit operations
// R07 - mode bit 7 stops or enables conversion
// R08 - time field bits 5..3 pick 288 to 96 main-clock cycles
// R09 - mode bit 0 runs the boost reference generator
// R10 - stopped, waiting with reference only, or converting
// R11 - first result after enabling with reference off is invalid
// R12 - software waits 14 us after reference enable before starting
// R13 - software picks a time between 14 us and the grade limit
// R14 - software stops conversion before changing the time field
// R15 - mode writes insert a bus wait cycle
// R16 - without power-fail, interrupt after every completed conversion; here none if mode bit 7 clears on the completing edge
// R17 - threshold compares with the upper 8 result bits only
// R18 - polarity zero: fire at or above; polarity one: fire below
// R19 - three-bit channel select picks input n for code n
// R20 - cycle counter times conversions and restarts while enabled
//
// Chosen here: the AXI4-Lite interface to the registers.
module sapf_top #(
   parameter int unsigned NUM_CHANNELS = sapf_pkg::NUM_CH
) (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // axi4-lite write address
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [sapf_pkg::ADDR_W-1:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   // axi4-lite write response
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   // axi4-lite read address
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [sapf_pkg::ADDR_W-1:0] s_axi_araddr,
   // axi4-lite read data
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   // analog front end
   output logic [2:0]                       channel_select,
   output logic [NUM_CHANNELS-1:0]          digital_input_enable,
   output logic                             sample_hold,
   output logic [9:0]                       approximation_register,
   output logic                             reference_generator_enable,
   input  wire logic                        comparator_high,
   // event
   output logic                             conversion_irq
);
   // the channel field and input mask are sized for eight inputs
   if (NUM_CHANNELS != sapf_pkg::NUM_CH) begin : g_chk
      $error("sapf_top supports exactly eight analog inputs");
   end

   sapf_conv_if conv ();

   // registers
   logic [7:0]  mode_q;
   logic [7:0]  chan_q;
   logic [7:0]  pfmode_q;
   logic [7:0]  pfthr_q;
   logic [9:0]  result_q;
   logic        invalid_q;
   logic        first_pend_q;
   logic        irq_q;
   logic [NUM_CHANNELS-1:0] dig_en_q;
   // bus state
   logic [15:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_have_q;
   logic        w_have_q;
   logic        wwait_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic [15:0] raddr_q;
   logic        ar_have_q;
   logic        rwait_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   // comparator synchroniser
   logic        cmp_s1_q;
   logic        cmp_s2_q;
   logic        cmp_s3_q;
   logic        cmp_filt_q;
   logic        cmp_now;
   logic        commit;
   logic        pf_pass;

   // word index taken from a byte address
   function automatic logic [15:0] word_index(
      input logic [sapf_pkg::ADDR_W-1:0] addr);
      word_index = addr[sapf_pkg::ADDR_W-1:2];
   endfunction : word_index

   // any index that answers with data
   function automatic logic is_mapped(input logic [15:0] idx);
      is_mapped = (idx == sapf_pkg::IDX_RESULT) ||
                  (idx == sapf_pkg::IDX_MODE)   ||
                  (idx == sapf_pkg::IDX_CHAN)   ||
                  (idx == sapf_pkg::IDX_PFMODE) ||
                  (idx == sapf_pkg::IDX_PFTHR)  ||
                  (idx == sapf_pkg::IDX_STATUS);
   endfunction : is_mapped

   // comparator pin: three stages, value changes once stages two and
   // three agree; the agreed value is used at once to save a cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_s1_q   <= 1'b0;
         cmp_s2_q   <= 1'b0;
         cmp_s3_q   <= 1'b0;
         cmp_filt_q <= 1'b0;
      end else begin
         cmp_s1_q <= comparator_high;
         cmp_s2_q <= cmp_s1_q;
         cmp_s3_q <= cmp_s2_q;
         if (cmp_s2_q == cmp_s3_q) begin
            cmp_filt_q <= cmp_s3_q;
         end
      end
   end
   assign cmp_now = (cmp_s2_q == cmp_s3_q) ? cmp_s3_q : cmp_filt_q;

   // sequencer link
   assign conv.run       = mode_q[sapf_pkg::MODE_RUN_BIT]; // [R07] [R10]
   assign conv.time_code = mode_q[sapf_pkg::MODE_TSEL_LSB +: 3]; // [R08]
   assign conv.cmp_high  = cmp_now;

   sapf_sar u_sar (
      .aclk    (aclk),
      .aresetn (aresetn),
      .conv    (conv)
   );

   // write channel: address and data taken in any order; the commit
   // is followed by one wait cycle before the response
   assign commit = aw_have_q && w_have_q && !wwait_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         wwait_q   <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= sapf_pkg::RESP_OKAY;
         waddr_q   <= 16'h0000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            waddr_q   <= word_index(s_axi_awaddr);
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
         end
         wwait_q <= commit; // [R15]
         if (wwait_q) begin
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(waddr_q) ? sapf_pkg::RESP_OKAY
                                           : sapf_pkg::RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // register writes; low byte lane only, reserved bits forced to zero.
   // bit operations reach here as read-modify-write of the whole byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q   <= sapf_pkg::RST_REG8; // [R06]
         chan_q   <= sapf_pkg::RST_REG8;
         pfmode_q <= sapf_pkg::RST_REG8;
         pfthr_q  <= sapf_pkg::RST_REG8;
      end else if (commit && wstrb_q[0]) begin
         unique case (waddr_q)
            sapf_pkg::IDX_MODE:
               mode_q <= wdata_q[7:0] & sapf_pkg::MODE_MASK; // [R06]
            sapf_pkg::IDX_CHAN:
               chan_q <= wdata_q[7:0] & sapf_pkg::CHAN_MASK; // [R19]
            sapf_pkg::IDX_PFMODE:
               pfmode_q <= wdata_q[7:0] & sapf_pkg::PF_MASK;
            sapf_pkg::IDX_PFTHR:
               pfthr_q <= wdata_q[7:0];
            default: ; // result, status and holes ignore writes
         endcase
      end
   end

   // read channel with one wait cycle, like the write side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_have_q <= 1'b0;
         rwait_q   <= 1'b0;
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= sapf_pkg::RESP_OKAY;
         raddr_q   <= 16'h0000;
      end else begin
         rwait_q <= 1'b0;
         if (s_axi_arvalid && arready_q) begin
            raddr_q   <= word_index(s_axi_araddr);
            ar_have_q <= 1'b1;
            arready_q <= 1'b0;
         end
         if (ar_have_q && !rwait_q && !rvalid_q) begin
            rwait_q <= 1'b1;
         end
         if (rwait_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(raddr_q) ? sapf_pkg::RESP_OKAY
                                           : sapf_pkg::RESP_SLVERR;
            unique case (raddr_q)
               sapf_pkg::IDX_RESULT:
                  rdata_q <= {16'h0000, result_q, 6'h00}; // [R04]
               sapf_pkg::IDX_MODE:   rdata_q <= {24'h000000, mode_q};
               sapf_pkg::IDX_CHAN:   rdata_q <= {24'h000000, chan_q};
               sapf_pkg::IDX_PFMODE: rdata_q <= {24'h000000, pfmode_q};
               sapf_pkg::IDX_PFTHR:  rdata_q <= {24'h000000, pfthr_q};
               sapf_pkg::IDX_STATUS:
                  rdata_q <= {29'h0000_0000,
                              mode_q[sapf_pkg::MODE_REF_BIT],
                              invalid_q, conv.active};
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            ar_have_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // compare upper result byte against threshold; uses the fresh result
   always_comb begin
      pf_pass = 1'b1; // [R16]
      if (pfmode_q[sapf_pkg::PF_EN_BIT]) begin // [R05]
         if (pfmode_q[sapf_pkg::PF_POL_BIT]) begin
            pf_pass = (conv.result[9:2] < pfthr_q); // [R17] [R18]
         end else begin
            pf_pass = (conv.result[9:2] >= pfthr_q); // [R17] [R18]
         end
      end
   end

   // result transfer on each completion; interrupt pulse on each completion that passes the power-fail compare while mode bit 7 is still set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= sapf_pkg::RST_RESULT;
         irq_q    <= 1'b0;
      end else begin
         irq_q <= conv.done && pf_pass && conv.run; // [R05] [R16]
         if (conv.done) begin
            result_q <= conv.result; // [R03] [R04]
         end
      end
   end

   // a start with the reference off marks the first result invalid;
   // the mark stays until a later completion replaces the result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_pend_q <= 1'b0;
         invalid_q    <= 1'b0;
      end else begin
         if (commit && wstrb_q[0] && waddr_q == sapf_pkg::IDX_MODE &&
             !mode_q[sapf_pkg::MODE_RUN_BIT] &&
             wdata_q[sapf_pkg::MODE_RUN_BIT] &&
             !wdata_q[sapf_pkg::MODE_REF_BIT]) begin
            first_pend_q <= 1'b1; // [R11]
         end else if (conv.done) begin
            first_pend_q <= 1'b0;
         end
         if (conv.done) begin
            invalid_q <= first_pend_q; // [R11]
         end
      end
   end

   // pin routing: only the selected input leaves the digital path,
   // and only while the converter is enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dig_en_q <= {NUM_CHANNELS{1'b1}};
      end else if (mode_q[sapf_pkg::MODE_RUN_BIT]) begin
         dig_en_q <= ~(NUM_CHANNELS'(1) << chan_q[2:0]); // [R01] [R19]
      end else begin
         dig_en_q <= {NUM_CHANNELS{1'b1}};
      end
   end

   // outputs
   assign s_axi_awready              = awready_q;
   assign s_axi_wready               = wready_q;
   assign s_axi_bvalid               = bvalid_q;
   assign s_axi_bresp                = bresp_q;
   assign s_axi_arready              = arready_q;
   assign s_axi_rvalid               = rvalid_q;
   assign s_axi_rdata                = rdata_q;
   assign s_axi_rresp                = rresp_q;
   assign channel_select             = chan_q[2:0]; // [R19]
   assign digital_input_enable       = dig_en_q;
   assign sample_hold                = conv.sampling; // [R02]
   assign approximation_register     = conv.approx;
   assign reference_generator_enable = mode_q[sapf_pkg::MODE_REF_BIT]; // [R09]
   assign conversion_irq             = irq_q;
endmodule : sapf_top

// [bench/sapf_top_monitor.sv]
// assertion checker bound to the converter control top
module sapf_top_monitor #(
   parameter int unsigned NUM_CHANNELS = 8
) (
   // clock and reset
   input wire logic                    aclk,
   input wire logic                    aresetn,
   // register bus
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic [1:0]              s_axi_bresp,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic                    s_axi_rvalid,
   // front end and event
   input wire logic [2:0]              channel_select,
   input wire logic [NUM_CHANNELS-1:0] digital_input_enable,
   input wire logic                    sample_hold,
   input wire logic [9:0]              approximation_register,
   input wire logic                    reference_generator_enable,
   input wire logic                    conversion_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // when some pin left digital use, it is the selected one and the only one
   property p_sel_only;
      !(&digital_input_enable) |-> !digital_input_enable[channel_select]
         && $countones(digital_input_enable) == NUM_CHANNELS - 1;
   endproperty
   a_sel_only: assert property (p_sel_only)
      else $error("digital enable does not match channel");
   property p_sample_min;
      $rose(sample_hold) |-> (sample_hold || &digital_input_enable)[*8];
   endproperty
   a_sample_min: assert property (p_sample_min)
      else $error("sampling cut short");
   property p_msb_first;
      $fell(sample_hold) && !(&digital_input_enable)
         |-> ##[0:1] approximation_register == 10'h200;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first trial is not the top bit");
   property p_irq_pulse;
      conversion_irq |=> !conversion_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("event longer than one cycle");
   property p_irq_run;
      conversion_irq |-> !(&digital_input_enable);
   endproperty
   a_irq_run: assert property (p_irq_run)
      else $error("event while stopped");
   property p_reset_idle;
      $rose(aresetn) |-> !reference_generator_enable && !conversion_irq
         && &digital_input_enable;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("not idle after reset");
   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer timing wrong");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
   endproperty
   a_b_done: assert property (p_b_done)
      else $error("write channel not released");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##[1:2] s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer timing wrong");

   c_irq: cover property (conversion_irq);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_sample: cover property ($rose(sample_hold));
endmodule : sapf_top_monitor

bind sapf_top sapf_top_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) u_mon (.*);

// [bench/sapf_afe_model.sv]
// behavioural analog front end: selector, sample and hold, comparator
module sapf_afe_model (
   // clock
   input  wire logic        aclk,
   // from the control block
   input  wire logic [2:0]  channel_select,
   input  wire logic        sample_hold,
   input  wire logic [9:0]  approximation_register,
   // eight input levels, ten bits each
   input  wire logic [79:0] analog_levels,
   // to the control block
   output logic             comparator_high
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held_q = 10'h155;

   // follow the input while sampling, frozen during hold
   always_ff @(posedge aclk) begin
      if (sample_hold === 1'b1)
         held_q <= analog_levels[channel_select*10 +: 10];
   end
   // high when the held level is at or above the tap
   assign comparator_high = held_q >= approximation_register;
endmodule : sapf_afe_model

// [bench/tb_sapf_top.sv]
// self-checking bench for the converter control top
module tb_sapf_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, comparator_high, conversion_irq;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, sample_hold;
   logic        reference_generator_enable;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  channel_select;
   logic [7:0]  digital_input_enable;
   logic [9:0]  approximation_register;
   logic [79:0] analog_levels;
   int          n_errors = 0, comparisons = 0, cyc = 0, n_irq = 0, t0, n0;
   localparam logic [9:0] LVL = 10'h2b7;
   localparam logic [1:0] OK = 2'h0;
   localparam logic [2:0] CODE [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
   localparam int         LEN [6] = '{288, 240, 192, 144, 120, 96};
   localparam logic [7:0] POWER_FAIL_MODE [4] = '{8'h80, 8'h80, 8'hc0, 8'hc0};
   localparam logic [7:0] THR [4] = '{8'had, 8'hae, 8'hae, 8'had};

   sapf_top dut (.*);
   sapf_afe_model afe (.*);

   // 100 MHz main clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // cycle and event counters
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (conversion_irq === 1'b1) n_irq <= n_irq + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // address and data offered together, bready held until the answer
   task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                     input logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(resp));
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                     input logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk(32'(s_axi_rresp), 32'(resp));
   endtask : rd

   task automatic wait_irq;
      do @(posedge aclk); while (conversion_irq !== 1'b1);
   endtask : wait_irq

   task automatic test_done;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   // hang guard, well past the expected run of some 6k cycles
   initial begin
      #300us;
      n_errors++;
      test_done();
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      analog_levels = {8{10'h0f0}};
      analog_levels[50 +: 10] = LVL;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, masks and an unmapped place
      rd(sapf_pkg::IDX_MODE, 32'h0, OK);
      rd(sapf_pkg::IDX_PFMODE, 32'h0, OK);
      rd(16'h0100, 32'h0, sapf_pkg::RESP_SLVERR);
      wr(16'h0100, 8'hff, sapf_pkg::RESP_SLVERR);
      wr(sapf_pkg::IDX_MODE, 8'h7e, OK);
      rd(sapf_pkg::IDX_MODE, 32'h38, OK);
      wr(sapf_pkg::IDX_CHAN, 8'h05, OK);
      // start with the reference off: first result flagged
      wr(sapf_pkg::IDX_MODE, 8'hb0, OK);
      chk(32'(digital_input_enable), 32'hdf);
      wait_irq();
      rd(sapf_pkg::IDX_STATUS, 32'h3, OK);
      rd(sapf_pkg::IDX_RESULT, {16'h0, LVL, 6'h0}, OK);
      wait_irq();
      rd(sapf_pkg::IDX_STATUS, 32'h1, OK);
      // every permitted time code, stopping before each change
      foreach (CODE[i]) begin
         wr(sapf_pkg::IDX_MODE, 8'h01, OK);
         if (i == 0) repeat (1400) @(posedge aclk);
         wr(sapf_pkg::IDX_MODE, {2'h2, CODE[i], 3'h1}, OK);
         chk(32'(reference_generator_enable), 32'h1);
         wait_irq();
         t0 = cyc;
         wait_irq();
         chk(32'(cyc - t0), 32'(LEN[i]));
      end
      // power-fail compare on upper result byte 8'had
      foreach (POWER_FAIL_MODE[i]) begin
         wr(sapf_pkg::IDX_PFTHR, THR[i], OK);
         wr(sapf_pkg::IDX_PFMODE, POWER_FAIL_MODE[i], OK);
         n0 = n_irq;
         repeat (300) @(posedge aclk);
         chk(32'(n_irq != n0), 32'(i % 2 == 0));
      end
      wr(sapf_pkg::IDX_PFMODE, 8'h00, OK);
      n0 = n_irq;
      repeat (300) @(posedge aclk);
      chk(32'(n_irq - n0 >= 3), 32'h1);
      // full stop: pins back to digital, no more events
      wr(sapf_pkg::IDX_MODE, 8'h00, OK);
      chk(32'(digital_input_enable), 32'hff);
      chk(32'(reference_generator_enable), 32'h0);
      n0 = n_irq;
      repeat (300) @(posedge aclk);
      chk(32'(n_irq - n0), 32'h0);
      test_done();
   end
endmodule : tb_sapf_top
